/* hw/xba_pkg.sv */
// Constants and types for the shared external bus arbitration block.
// Assumes one 50 MHz clock and node straps that are stable after reset.
// Contract
// [R1] Host holds bus request while it needs bus
// [R2] Owner releases bus, then asserts host grant
// [R3] Released bus outputs go high impedance
// [R4] Host request outranks every node request
// [R5] Grant held low until host request drops
// [R6] Only bus master drives grant; others monitor
// [R7] Host selects this device with chip select
// [R8] Wait acknowledge low until host access completes
// [R9] Acknowledge open drain unless drive mode set
// [R10] Acknowledge driven only with select and request
// [R11] External DMA pair a channel 7, b 6
// [R12] Drive own request line, monitor the rest
// [R13] Node number picks line; zero means single
// [R14] Node number fixed or changed in reset
// [R15] Priority select high rotating, low fixed
// [R16] Priority select equal everywhere, same cycle
// [R17] Slave core priority access preempts background DMA
// [R18] Core priority line open drain, pulls low
// [R19] Fixed lowest node wins; rotating demotes owner
package xba_pkg;

   // ------------------------------------------------------------
   // Sizes and codes
   // ------------------------------------------------------------
   localparam int XBA_NODES = 6;
   localparam logic [2:0] XBA_NODE_NONE = 3'h0;
   localparam logic [2:0] XBA_NODE_LAST = 3'h6;
   localparam logic [5:0] XBA_LINES_IDLE = 6'h00;
   localparam logic [5:0] XBA_LINE_ONE = 6'h01;

   // ------------------------------------------------------------
   // Ownership states, Gray along slave-master-yield-host
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      XBA_SLAVE  = 2'h0,
      XBA_MASTER = 2'h1,
      XBA_YIELD  = 2'h3,
      XBA_HOST   = 2'h2
   } xba_state_t;

endpackage

/* hw/xba_node_sel.sv */
// Decodes the node number into the one request line this node owns.
// Assumes the node number is already held stable by the caller.
`timescale 1ns/1ns
module xba_node_sel (
   input wire logic [2:0] node_number,
   output logic [5:0] line_onehot,
   output logic single_node
);

   // ------------------------------------------------------------
   // Per-line decode
   // ------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < xba_pkg::XBA_NODES; gi++) begin : g_line
         assign line_onehot[gi] = (node_number == 3'(gi + 1)); // R13
      end
   endgenerate

   assign single_node = (node_number == xba_pkg::XBA_NODE_NONE); // R13

endmodule

/* hw/xba_prio_pick.sv */
// Picks the winning node among asserted request lines.
// Assumes every node sees the same request vector and select level.
`timescale 1ns/1ns
module xba_prio_pick (
   input wire logic [5:0] req,
   input wire logic rotate,
   input wire logic [2:0] last_owner,
   output logic [2:0] winner
);

   // ------------------------------------------------------------
   // Search from the start index; lowest offset wins
   // ------------------------------------------------------------
   always_comb begin
      int start;
      int idx;
      start = 0;
      idx = 0;
      winner = xba_pkg::XBA_NODE_NONE;
      // Rotation starts just past the last owner, demoting it
      if (rotate && last_owner != xba_pkg::XBA_NODE_NONE && last_owner != xba_pkg::XBA_NODE_LAST) begin
         start = int'(last_owner); // R15 R19
      end
      for (int k = xba_pkg::XBA_NODES - 1; k >= 0; k--) begin
         idx = (start + k) % xba_pkg::XBA_NODES;
         if (req[idx]) begin
            winner = 3'(idx + 1); // R19
         end
      end
   end

endmodule

/* hw/xba_arbiter.sv */
// Bus ownership for one node: host handshake, node arbitration,
// wait acknowledge and external DMA pin mapping.
// Assumes all pins are synchronous to clk; open-drain and two-way
// pins are resolved outside from the out/oe pairs.
`timescale 1ns/1ns
module xba_arbiter (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic host_bus_request_n,
   input wire logic chip_select_n,
   input wire logic host_bus_grant_n_in,
   output logic host_bus_grant_n_out,
   output logic host_bus_grant_oe,
   output logic host_wait_ack_out,
   output logic host_wait_ack_oe,
   input wire logic ack_drive_mode,
   input wire logic access_busy,
   input wire logic [2:0] node_number,
   input wire logic rotate_priority_sel,
   input wire logic [5:0] node_bus_requests_in,
   output logic [5:0] node_bus_requests_out,
   output logic [5:0] node_bus_requests_oe,
   input wire logic core_req,
   input wire logic dma_req,
   input wire logic core_priority_access_in,
   output logic core_priority_access_out,
   output logic core_priority_access_oe,
   output logic bus_drive_oe,
   output logic bus_master,
   input wire logic ext_dma_req_a_n,
   input wire logic ext_dma_req_b_n,
   input wire logic dma_chan7_grant,
   input wire logic dma_chan6_grant,
   output logic dma_chan7_req,
   output logic dma_chan6_req,
   output logic ext_dma_grant_a_n_out,
   output logic ext_dma_grant_b_n_out,
   output logic ext_dma_grant_oe
);

   // ------------------------------------------------------------
   // Node number capture
   // ------------------------------------------------------------
   logic [2:0] node_q;
   logic [2:0] node_d;
   logic node_cap_q;
   logic node_cap_d;
   logic [5:0] node_onehot;
   logic single_node;

   // Caught once after reset; later strap changes are ignored
   always_comb begin
      node_d = node_cap_q ? node_q : node_number; // R14
      node_cap_d = 1'b1;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         node_q <= xba_pkg::XBA_NODE_NONE;
         node_cap_q <= 1'b0;
      end else begin
         node_q <= node_d;
         node_cap_q <= node_cap_d;
      end
   end

   xba_node_sel u_node_sel (
      .node_number(node_q),
      .line_onehot(node_onehot),
      .single_node(single_node)
   );

   // ------------------------------------------------------------
   // Request vector and winner
   // ------------------------------------------------------------
   logic own_br_q;
   logic own_br_d;
   logic [5:0] req_vec;
   logic [2:0] owner_q;
   logic [2:0] owner_d;
   logic [2:0] owner_idx;
   logic [2:0] winner;
   logic owner_req;
   logic host_req;
   logic host_holds;
   logic free_to_arb;
   logic am_owner;

   // Own line taken from the register, not the pad, to avoid a loop
   genvar gi;
   generate
      for (gi = 0; gi < xba_pkg::XBA_NODES; gi++) begin : g_req
         assign req_vec[gi] = node_onehot[gi] ? own_br_q : ~node_bus_requests_in[gi]; // R12
      end
   endgenerate

   assign host_req = ~host_bus_request_n; // R1
   assign host_holds = ~host_bus_grant_n_in; // R6
   assign owner_idx = owner_q - 3'h1;
   assign owner_req = (owner_q != xba_pkg::XBA_NODE_NONE) && req_vec[owner_idx];
   assign free_to_arb = ~host_holds & ~host_req & ~owner_req; // R4
   // No ownership until the strap is caught, else node 0 looks single
   assign am_owner = node_cap_q & (single_node | (owner_q == node_q));

   xba_prio_pick u_prio_pick (
      .req(req_vec),
      .rotate(rotate_priority_sel),
      .last_owner(owner_q),
      .winner(winner)
   );

   // Owner parks on the bus until someone else asks
   always_comb begin
      owner_d = owner_q;
      if (free_to_arb && winner != xba_pkg::XBA_NODE_NONE) begin
         owner_d = winner; // R15 R19
      end
   end

   // ------------------------------------------------------------
   // Ownership state machine
   // ------------------------------------------------------------
   xba_pkg::xba_state_t state_q;
   xba_pkg::xba_state_t state_d;
   logic cpa_yield;
   logic cpa_oe_q;
   logic cpa_oe_d;
   logic am_owner_next;

   // Stop pulling the shared line at the edge that makes us owner
   assign am_owner_next = node_cap_q & (owner_d == node_q);

   // A master busy only with background DMA steps aside for a core
   assign cpa_yield = am_owner & (state_q == xba_pkg::XBA_MASTER) & ~core_priority_access_in
                      & ~cpa_oe_q & ~core_req; // R17

   always_comb begin
      own_br_d = ~single_node & (core_req | dma_req) & ~cpa_yield; // R12 R17
      cpa_oe_d = ~single_node & core_req & ~am_owner_next; // R17 R18
      state_d = state_q;
      unique case (state_q)
         xba_pkg::XBA_SLAVE: begin
            if (am_owner && !host_holds && !host_req) begin
               state_d = xba_pkg::XBA_MASTER;
            end
         end
         xba_pkg::XBA_MASTER: begin
            if (host_req) begin
               state_d = xba_pkg::XBA_YIELD; // R2 R4
            end else if (!am_owner) begin
               state_d = xba_pkg::XBA_SLAVE;
            end
         end
         xba_pkg::XBA_YIELD: begin
            state_d = xba_pkg::XBA_HOST; // R2
         end
         xba_pkg::XBA_HOST: begin
            if (!host_req) begin
               state_d = am_owner ? xba_pkg::XBA_MASTER : xba_pkg::XBA_SLAVE; // R5
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= xba_pkg::XBA_SLAVE;
         owner_q <= xba_pkg::XBA_NODE_NONE;
         own_br_q <= 1'b0;
         cpa_oe_q <= 1'b0;
      end else begin
         state_q <= state_d;
         owner_q <= owner_d;
         own_br_q <= own_br_d;
         cpa_oe_q <= cpa_oe_d;
      end
   end

   // ------------------------------------------------------------
   // Pin drive
   // ------------------------------------------------------------
   logic ack_sel;
   logic hbg_out_d;
   logic hbg_oe_d;
   logic ack_out_d;
   logic ack_oe_d;
   logic bus_oe_d;
   logic master_d;
   logic [5:0] br_out_d;

   assign ack_sel = ~chip_select_n & host_req; // R7 R10

   always_comb begin
      bus_oe_d = (state_d == xba_pkg::XBA_MASTER); // R3
      master_d = (state_d == xba_pkg::XBA_MASTER);
      hbg_oe_d = (state_d != xba_pkg::XBA_SLAVE); // R6
      hbg_out_d = (state_d != xba_pkg::XBA_HOST); // R5
      // Open drain only ever pulls low; drive mode adds the high level
      ack_out_d = ack_drive_mode & ~access_busy; // R8 R9
      ack_oe_d = ack_sel & (ack_drive_mode | access_busy); // R9 R10
      br_out_d = {xba_pkg::XBA_NODES{~own_br_d}};
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         bus_drive_oe <= 1'b0;
         bus_master <= 1'b0;
         host_bus_grant_oe <= 1'b0;
         host_bus_grant_n_out <= 1'b1;
         host_wait_ack_out <= 1'b0;
         host_wait_ack_oe <= 1'b0;
         node_bus_requests_out <= ~xba_pkg::XBA_LINES_IDLE;
         node_bus_requests_oe <= xba_pkg::XBA_LINES_IDLE;
         core_priority_access_out <= 1'b0;
         core_priority_access_oe <= 1'b0;
      end else begin
         bus_drive_oe <= bus_oe_d;
         bus_master <= master_d;
         host_bus_grant_oe <= hbg_oe_d;
         host_bus_grant_n_out <= hbg_out_d;
         host_wait_ack_out <= ack_out_d;
         host_wait_ack_oe <= ack_oe_d;
         node_bus_requests_out <= br_out_d;
         node_bus_requests_oe <= node_onehot & {xba_pkg::XBA_NODES{node_cap_q}}; // R12 R13
         core_priority_access_out <= 1'b0; // R18
         core_priority_access_oe <= cpa_oe_d; // R18
      end
   end

   // ------------------------------------------------------------
   // External DMA pins
   // ------------------------------------------------------------
   // Grants only drive while this node owns the bus
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         dma_chan7_req <= 1'b0;
         dma_chan6_req <= 1'b0;
         ext_dma_grant_a_n_out <= 1'b1;
         ext_dma_grant_b_n_out <= 1'b1;
         ext_dma_grant_oe <= 1'b0;
      end else begin
         dma_chan7_req <= ~ext_dma_req_a_n; // R11
         dma_chan6_req <= ~ext_dma_req_b_n; // R11
         ext_dma_grant_a_n_out <= ~dma_chan7_grant; // R11
         ext_dma_grant_b_n_out <= ~dma_chan6_grant; // R11
         ext_dma_grant_oe <= bus_oe_d; // R11
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_yield_then_grant: assert property (@(posedge clk) disable iff (!reset_n) // R2
      state_q == xba_pkg::XBA_MASTER && host_req |-> ##1 state_q == xba_pkg::XBA_YIELD ##1
      state_q == xba_pkg::XBA_HOST)
      else $error("master did not hand over to host in two cycles");

   a_grant_bus_off: assert property (@(posedge clk) disable iff (!reset_n) // R3
      host_bus_grant_oe && !host_bus_grant_n_out |-> !bus_drive_oe && !ext_dma_grant_oe)
      else $error("bus driven while host granted");

   a_host_freeze_owner: assert property (@(posedge clk) disable iff (!reset_n) // R4
      host_req |=> owner_q == $past(owner_q))
      else $error("owner changed during host request");

   a_grant_hold_low: assert property (@(posedge clk) disable iff (!reset_n) // R5
      state_q == xba_pkg::XBA_HOST && host_req |=> !host_bus_grant_n_out && host_bus_grant_oe)
      else $error("grant not held low while host requests");

   a_grant_release: assert property (@(posedge clk) disable iff (!reset_n) // R5
      state_q == xba_pkg::XBA_HOST && !host_req |=> host_bus_grant_n_out)
      else $error("grant not released after host request dropped");

   a_grant_slave_quiet: assert property (@(posedge clk) disable iff (!reset_n) // R6
      $past(state_q) == xba_pkg::XBA_SLAVE && state_q == xba_pkg::XBA_SLAVE |-> !host_bus_grant_oe)
      else $error("slave drives host grant");

   a_ack_wait_low: assert property (@(posedge clk) disable iff (!reset_n) // R8
      ack_sel && access_busy |=> host_wait_ack_oe && !host_wait_ack_out)
      else $error("wait not signalled during busy access");

   a_ack_open_drain: assert property (@(posedge clk) disable iff (!reset_n) // R9
      !$past(ack_drive_mode) && host_wait_ack_oe |-> !host_wait_ack_out)
      else $error("acknowledge driven high in open drain mode");

   a_ack_only_sel: assert property (@(posedge clk) disable iff (!reset_n) // R10
      host_wait_ack_oe |-> $past(ack_sel))
      else $error("acknowledge driven without select and request");

   a_dma_chan_map: assert property (@(posedge clk) disable iff (!reset_n) // R11
      !ext_dma_req_a_n && ext_dma_req_b_n |=> dma_chan7_req && !dma_chan6_req)
      else $error("external DMA request on wrong channel");

   a_own_line_only: assert property (@(posedge clk) disable iff (!reset_n) // R12 R13
      node_cap_q |=> $onehot0(node_bus_requests_oe) && node_bus_requests_oe == $past(node_onehot))
      else $error("request line drive does not match node number");

   a_fixed_lowest: assert property (@(posedge clk) disable iff (!reset_n) // R15 R19
      free_to_arb && !rotate_priority_sel && winner != xba_pkg::XBA_NODE_NONE |=>
      ($past(req_vec) & ((xba_pkg::XBA_LINE_ONE << owner_idx) - xba_pkg::XBA_LINE_ONE)) == xba_pkg::XBA_LINES_IDLE)
      else $error("fixed priority passed over a lower node");

   a_cpa_preempt: assert property (@(posedge clk) disable iff (!reset_n) // R17
      cpa_yield |=> !own_br_q ##1 node_bus_requests_out[0] == 1'b1)
      else $error("background DMA master kept its request");

   a_cpa_pull_low: assert property (@(posedge clk) disable iff (!reset_n) // R18
      core_priority_access_oe |-> !core_priority_access_out && !am_owner)
      else $error("core priority line driven high or by owner");

endmodule

/* tb/xba_far_side.sv */
// Far side model: host processor and peer nodes on the shared bus.
// Assumes the bench changes host and peer wishes just after a rising edge.
`timescale 1ns/1ns
module xba_far_side (
   input wire logic host_want,
   input wire logic host_sel,
   input wire logic [5:0] peer_req,
   input wire logic [5:0] br_out,
   input wire logic [5:0] br_oe,
   input wire logic grant_out,
   input wire logic grant_oe,
   input wire logic cpa_out,
   input wire logic cpa_oe,
   input wire logic peer_cpa,
   output logic host_bus_request_n,
   output logic chip_select_n,
   output logic [5:0] br_in,
   output logic grant_in,
   output logic cpa_in
);
   // ------------------------------------------------------------
   // Host
   // ------------------------------------------------------------
   // Held for as long as the host wants the bus
   assign host_bus_request_n = ~host_want;
   assign chip_select_n = ~host_sel;

   // ------------------------------------------------------------
   // Wired lines
   // ------------------------------------------------------------
   // Lines with no node behind them idle high as if tied
   assign br_in = (br_oe & br_out) | (~br_oe & ~peer_req);
   assign grant_in = grant_oe ? grant_out : 1'b1;
   // Pull-up wins when nobody pulls low
   assign cpa_in = (cpa_oe ? cpa_out : 1'b1) & ~peer_cpa;
endmodule

/* tb/tb_external_bus_arbitration_host_port.sv */
// Self-checking bench for the bus arbitration block.
// Assumes the far side model resolves every wired line.
`timescale 1ns/1ns
module tb_external_bus_arbitration_host_port;
   typedef struct {string name; int sel; logic [7:0] exp;} xba_note_t;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic host_want = 1'b0, host_sel = 1'b0, ack_drive_mode = 1'b0, access_busy = 1'b0;
   logic [2:0] node_number = 3'h1;
   logic rotate_priority_sel = 1'b0, core_req = 1'b0, dma_req = 1'b0, peer_cpa = 1'b0;
   logic [5:0] peer_req = 6'h00;
   logic ext_a_n = 1'b1, ext_b_n = 1'b1, g7 = 1'b0, g6 = 1'b0;
   logic hbr_n, cs_n, grant_in, grant_out, grant_oe, ack_out, ack_oe, cpa_in, cpa_out, cpa_oe;
   logic drive_oe, master, req7, req6, gnt_a_n, gnt_b_n, gnt_oe;
   logic [5:0] br_in, br_out, br_oe;
   xba_note_t notes[$];
   xba_note_t n;
   int mismatches = 0, checks_done = 0, cycles = 0;
   logic [31:0] rnd_q = 32'h0000_0021;

   // ------------------------------------------------------------
   // Instances
   // ------------------------------------------------------------
   xba_arbiter uut (.clk(clk), .reset_n(reset_n), .host_bus_request_n(hbr_n), .chip_select_n(cs_n),
      .host_bus_grant_n_in(grant_in), .host_bus_grant_n_out(grant_out), .host_bus_grant_oe(grant_oe),
      .host_wait_ack_out(ack_out), .host_wait_ack_oe(ack_oe), .ack_drive_mode(ack_drive_mode),
      .access_busy(access_busy), .node_number(node_number), .rotate_priority_sel(rotate_priority_sel),
      .node_bus_requests_in(br_in), .node_bus_requests_out(br_out), .node_bus_requests_oe(br_oe),
      .core_req(core_req), .dma_req(dma_req), .core_priority_access_in(cpa_in),
      .core_priority_access_out(cpa_out), .core_priority_access_oe(cpa_oe), .bus_drive_oe(drive_oe),
      .bus_master(master), .ext_dma_req_a_n(ext_a_n), .ext_dma_req_b_n(ext_b_n), .dma_chan7_grant(g7),
      .dma_chan6_grant(g6), .dma_chan7_req(req7), .dma_chan6_req(req6), .ext_dma_grant_a_n_out(gnt_a_n),
      .ext_dma_grant_b_n_out(gnt_b_n), .ext_dma_grant_oe(gnt_oe));
   xba_far_side far (.host_want(host_want), .host_sel(host_sel), .peer_req(peer_req), .br_out(br_out),
      .br_oe(br_oe), .grant_out(grant_out), .grant_oe(grant_oe), .cpa_out(cpa_out), .cpa_oe(cpa_oe),
      .host_bus_request_n(hbr_n), .chip_select_n(cs_n), .br_in(br_in), .grant_in(grant_in),
      .cpa_in(cpa_in), .peer_cpa(peer_cpa));

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   always #10 clk = ~clk;
   function automatic logic [31:0] xorshift(input logic [31:0] v);
      logic [31:0] x;
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function automatic logic [7:0] observe(input int sel);
      case (sel)
         0: return {7'h00, master};
         1: return {7'h00, drive_oe};
         2: return {7'h00, grant_out};
         3: return {7'h00, grant_oe};
         4: return {7'h00, ack_oe};
         5: return {7'h00, cpa_oe};
         6: return {2'h0, br_oe};
         7: return {4'h0, req7, req6, gnt_a_n, gnt_b_n};
         8: return {7'h00, gnt_oe};
         10: return {2'h0, br_out};
         default: return {7'h00, ack_out};
      endcase
   endfunction
   task automatic note(input string name, input int sel, input logic [7:0] exp);
      notes.push_back('{name, sel, exp});
   endtask
   task automatic compare(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic tick(input int cnt);
      repeat (cnt) @(posedge clk);
   endtask
   // Bounded wait; the following note catches a miss
   task automatic wait_master(input int limit);
      repeat (limit) begin
         @(negedge clk);
         if (master === 1'b1) break;
      end
      @(posedge clk);
   endtask
   task automatic do_reset(input logic [2:0] node, input logic rot);
      reset_n <= 1'b0;
      node_number <= node;
      rotate_priority_sel <= rot;
      tick(6);
      reset_n <= 1'b1;
      tick(3);
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // Watcher and timeout
   // ------------------------------------------------------------
   always @(negedge clk) begin
      while (notes.size() > 0) begin
         n = notes.pop_front();
         compare(n.name, observe(n.sel), n.exp);
      end
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         complete_run();
      end
   end

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial begin
      do_reset(3'h1, 1'b0);
      note("own line enable", 6, 8'h01);
      core_req <= 1'b1;
      wait_master(8);
      note("own bus", 1, 8'h01);
      host_want <= 1'b1;
      tick(1);
      note("bus released", 1, 8'h00);
      note("grant after release", 2, 8'h01);
      tick(1);
      note("grant low", 2, 8'h00);
      note("grant driven", 3, 8'h01);
      // Host access with wait states while holding the bus
      host_sel <= 1'b1;
      access_busy <= 1'b1;
      tick(1);
      note("ack wait enable", 4, 8'h01);
      note("ack wait level", 9, 8'h00);
      access_busy <= 1'b0;
      tick(1);
      note("ack open drain", 4, 8'h00);
      ack_drive_mode <= 1'b1;
      tick(1);
      note("ack driven", 4, 8'h01);
      note("ack ready", 9, 8'h01);
      host_sel <= 1'b0;
      tick(1);
      note("ack unselected", 4, 8'h00);
      note("grant held", 2, 8'h00);
      host_want <= 1'b0;
      tick(2);
      note("grant released", 2, 8'h01);
      note("bus retaken", 1, 8'h01);
      note("dma grant drive", 8, 8'h01);
      repeat (8) begin
         rnd_q = xorshift(rnd_q);
         ext_a_n <= rnd_q[0];
         ext_b_n <= rnd_q[1];
         g7 <= rnd_q[2];
         g6 <= rnd_q[3];
         tick(1);
         note("dma mapping", 7, {4'h0, ~rnd_q[0], ~rnd_q[1], ~rnd_q[2], ~rnd_q[3]});
      end
      // Peer core claims priority while we only run background DMA
      note("own line low", 10, 8'h00);
      core_req <= 1'b0;
      dma_req <= 1'b1;
      peer_cpa <= 1'b1;
      tick(1);
      note("dma yields to core", 10, 8'h3f);
      dma_req <= 1'b0;
      peer_cpa <= 1'b0;
      // Node 3 against peers 1 and 2; owner 2 hands over
      for (int r = 0; r < 2; r++) begin
         tick(1);
         core_req <= 1'b0;
         peer_req <= 6'h02;
         do_reset(3'h3, r[0]);
         note("own line enable", 6, 8'h04);
         tick(4);
         core_req <= 1'b1;
         peer_req <= 6'h03;
         tick(3);
         note("slave waits", 0, 8'h00);
         note("core priority", 5, 8'h01);
         peer_req <= 6'h01;
         wait_master(8);
         note("priority pick", 0, {7'h00, r[0]});
      end
      tick(1);
      peer_req <= 6'h00;
      do_reset(3'h0, 1'b0);
      note("single master", 0, 8'h01);
      note("single no line", 6, 8'h00);
      tick(2);
      complete_run();
   end
endmodule
